// >>> src/bkl_ctrl.v
/*
 Bus kneeling and ride height controller: cycle tick, sensor sample
 strobe, height compare with valve drive, kneeling state machine with
 interlocks, drive-off inhibit, plausibility faults and lamps.
 Assumes pins are asynchronous; height and speed words are held
 stable by the converter long enough for two-stage sampling.
*/
// Operation
// - No kneeling without lockable enable switch
// - Both manual and automatic kneeling paths
// - Manual control released: stop, then lift
// - Relower only after reaching normal height
// - Emergency switch turns auto lowering into lift
// - Lower only below 5 km/h
// - Hold drive-off inhibit while lowered
// - Auto lowering starts only with doors closed
// - Report 80 % travel before doors open
// - No lifting while a door fully open
// - Pause lifting on door reversing signal
// - Run control sequence every 25 ms
// - Compare height to nominal, drive valves
// - Parameters held in rewritable storage
// - Sample sensor over 50 per second, monitor
// - Plausibility check, output and store faults
// - Basic variant: 8-bit height counts
// - Newer variant: 16-bit tick values
// - Separate error, warning, kneeling lamps
// - Deny kneeling on low supply pressure
`timescale 1ns/10ps
`include "bkl_map.vh"
module bkl_ctrl #(
  parameter [31:0] CYCLE_CNT  = `BKL_CYCLE_CNT,
  parameter [31:0] SAMPLE_CNT = `BKL_SAMPLE_CNT
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Parameter storage write port, same clock domain
  input  wire        prm_we,
  input  wire [1:0]  prm_sel,
  input  wire [15:0] prm_wdata,
  input  wire        sensor_wide,
  // Driver controls, pins
  input  wire        kneel_enable_sw,
  input  wire        manual_lower_btn,
  input  wire        auto_lower_req,
  input  wire        emergency_sw,
  input  wire        supply_press_ok,
  // Door control, pins
  input  wire        doors_closed,
  input  wire        door_fully_open,
  input  wire        door_reversing,
  // Vehicle speed and height, pins
  input  wire [7:0]  speed_kmh,
  input  wire [15:0] height_raw,
  input  wire        sensor_fault_in,
  // Valve drivers
  output wire        valve_raise,
  output wire        valve_lower,
  // Door control and drivetrain
  output wire        lower_travel_80,
  output wire        drive_inhibit,
  // Indicators and status
  output wire        lamp_error,
  output wire        lamp_warning,
  output wire        lamp_kneeling,
  output wire [1:0]  kneel_state,
  output wire [3:0]  fault_store,
  output wire        sample_strobe,
  output wire        cycle_tick
);
  localparam [1:0] ST_NORMAL   = `BKL_ST_NORMAL;
  localparam [1:0] ST_LOWERING = `BKL_ST_LOWERING;
  localparam [1:0] ST_LOWERED  = `BKL_ST_LOWERED;
  localparam [1:0] ST_LIFTING  = `BKL_ST_LIFTING;
  localparam [7:0] SPEED_LIM   = `BKL_SPEED_LIMIT_KMH;
  localparam [6:0] TRAVEL_PCT  = `BKL_TRAVEL_PCT;

  // Synchronised pins
  wire [8:0]  pin_s;
  wire [15:0] height_s;
  wire [7:0]  speed_s;

  bkl_sync2 #(.W(9)) u_sync_pins (
    .clk     (clk),
    .reset_n (reset_n),
    .d       ({kneel_enable_sw, manual_lower_btn, auto_lower_req,
                emergency_sw, supply_press_ok, doors_closed,
                door_fully_open, door_reversing, sensor_fault_in}),
    .q       (pin_s)
  );
  bkl_sync2 #(.W(16)) u_sync_height (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (height_raw),
    .q       (height_s)
  );
  bkl_sync2 #(.W(8)) u_sync_speed (
    .clk     (clk),
    .reset_n (reset_n),
    .d       (speed_kmh),
    .q       (speed_s)
  );

  wire en_s    = pin_s[8];
  wire man_s   = pin_s[7];
  wire auto_s  = pin_s[6];
  wire emer_s  = pin_s[5];
  wire press_s = pin_s[4];
  wire closed_s = pin_s[3];
  wire open_s  = pin_s[2];
  wire rev_s   = pin_s[1];
  wire sflt_s  = pin_s[0];

  // Rewritable parameters: normal, kneel level, deadband
  reg [15:0] nom_normal_ff;
  reg [15:0] nom_kneel_ff;
  reg [15:0] deadband_ff;
  reg        wide_ff;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nom_normal_ff <= 16'h0080;
      nom_kneel_ff  <= 16'h0040;
      deadband_ff   <= 16'h0002;
      wide_ff       <= 1'b0;
    end else if (prm_we) begin
      case (prm_sel)
        2'h0: nom_normal_ff <= prm_wdata;
        2'h1: nom_kneel_ff  <= prm_wdata;
        2'h2: deadband_ff   <= prm_wdata;
        default: wide_ff    <= sensor_wide;
      endcase
    end
  end

  // Program cycle and sensor sample timers
  reg [31:0] cyc_cnt_ff;
  reg [31:0] smp_cnt_ff;
  reg        cycle_ff;
  reg        sample_ff;
  wire       cyc_end = (cyc_cnt_ff == CYCLE_CNT - 32'h1);
  wire       smp_end = (smp_cnt_ff == SAMPLE_CNT - 32'h1);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc_cnt_ff <= 32'h0;
      smp_cnt_ff <= 32'h0;
      cycle_ff   <= 1'b0;
      sample_ff  <= 1'b0;
    end else begin
      cyc_cnt_ff <= cyc_end ? 32'h0 : cyc_cnt_ff + 32'h1;
      smp_cnt_ff <= smp_end ? 32'h0 : smp_cnt_ff + 32'h1;
      cycle_ff   <= cyc_end;
      sample_ff  <= smp_end;
    end
  end

  // Height sample; basic variant keeps the low byte only
  reg [15:0] height_ff;
  reg        hvalid_ff;
  wire [15:0] height_cnv = wide_ff ? height_s
                                   : {8'h00, height_s[7:0]};

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      height_ff <= 16'h0;
      hvalid_ff <= 1'b0;
    end else if (sample_ff) begin
      height_ff <= height_cnv;
      hvalid_ff <= 1'b1;
    end
  end

  // Plausibility: sensor fault pin, out of range, kneel at or above normal
  reg  [3:0] fault_ff;
  wire       f_sensor = sflt_s;
  wire       f_range  = hvalid_ff && (height_ff == 16'h0 ||
                        (!wide_ff && height_ff[7:0] == 8'hff) ||
                        (wide_ff && height_ff == 16'hffff));
  wire       f_param  = (nom_kneel_ff >= nom_normal_ff);
  wire       f_press  = !press_s;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      fault_ff <= `BKL_FAULT_RST;
    else if (cycle_ff) // Sticky until reset: stored fault memory
      fault_ff <= fault_ff | {f_press, f_param, f_range, f_sensor};
  end

  // Kneeling state machine
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg       relower_ok_ff;
  reg       auto_mode_ff;
  reg       nxt_auto_mode;
  reg       man_prev_ff;

  wire at_normal = hvalid_ff && (height_ff + deadband_ff >= nom_normal_ff);
  wire at_kneel  = hvalid_ff && (height_ff <= nom_kneel_ff + deadband_ff);
  wire interlock = en_s
                && press_s
                && (speed_s < SPEED_LIM)
                && relower_ok_ff
                && !f_sensor;
  wire start_man  = man_s && !man_prev_ff;
  wire start_auto = auto_s && closed_s && !emer_s;
  wire lift_req   = !man_s && !auto_s;
  wire lift_block = open_s;

  always @* begin
    nxt_state     = state_ff;
    nxt_auto_mode = auto_mode_ff;
    case (state_ff)
      ST_NORMAL: begin
        if (interlock && start_man) begin
          nxt_state     = ST_LOWERING;
          nxt_auto_mode = 1'b0;
        end else if (interlock && start_auto) begin
          nxt_state     = ST_LOWERING;
          nxt_auto_mode = 1'b1;
        end
      end
      ST_LOWERING: begin
        if (!auto_mode_ff && !man_s)
          nxt_state = ST_LIFTING;
        else if (auto_mode_ff && emer_s)
          nxt_state = ST_LIFTING;
        else if (!en_s || speed_s >= SPEED_LIM)
          nxt_state = ST_LIFTING;
        else if (at_kneel)
          nxt_state = ST_LOWERED;
      end
      ST_LOWERED: begin
        if ((lift_req || !en_s || emer_s) && !lift_block)
          nxt_state = ST_LIFTING;
      end
      ST_LIFTING: begin
        if (at_normal)
          nxt_state = ST_NORMAL;
      end
      default: nxt_state = ST_NORMAL;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff      <= ST_NORMAL;
      auto_mode_ff  <= 1'b0;
      relower_ok_ff <= 1'b1;
      man_prev_ff   <= 1'b0;
    end else if (cycle_ff) begin
      state_ff     <= nxt_state;
      auto_mode_ff <= nxt_auto_mode;
      man_prev_ff  <= man_s;
      if (state_ff == ST_LOWERING && nxt_state == ST_LIFTING)
        relower_ok_ff <= 1'b0;
      else if (state_ff == ST_LIFTING && nxt_state == ST_NORMAL)
        relower_ok_ff <= 1'b1;
    end
  end

  // Nominal target and valve drive, refreshed once per cycle
  wire [15:0] target = (state_ff == ST_LOWERING || state_ff == ST_LOWERED)
                     ? nom_kneel_ff : nom_normal_ff;
  wire        too_low  = hvalid_ff && (height_ff + deadband_ff < target);
  wire        too_high = hvalid_ff && (height_ff > target + deadband_ff);
  // Lifting stays closed while door open or reversing
  wire        lift_pause = (state_ff == ST_LIFTING) &&
                           (rev_s || lift_block);

  reg [1:0] valve_ff;
  reg       travel_ff;
  reg       inhibit_ff;
  reg [2:0] lamp_ff;

  // Travel fraction: (normal - h) * 100 >= 80 * (normal - kneel)
  wire [15:0] span  = nom_normal_ff - nom_kneel_ff;
  wire [15:0] done  = (height_ff < nom_normal_ff) ?
                      nom_normal_ff - height_ff : 16'h0;
  wire [22:0] done_x = done * 7'd100;
  wire [22:0] span_x = span * TRAVEL_PCT;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valve_ff   <= `BKL_VALVE_RST;
      travel_ff  <= 1'b0;
      inhibit_ff <= 1'b0;
      lamp_ff    <= 3'h0;
    end else if (cycle_ff) begin
      valve_ff[1] <= too_low && !lift_pause && !f_sensor;
      valve_ff[0] <= too_high && !f_sensor &&
                     (state_ff == ST_LOWERING ||
                      state_ff == ST_NORMAL);
      travel_ff  <= (state_ff == ST_LOWERING || state_ff == ST_LOWERED)
                    && (done_x >= span_x);
      inhibit_ff <= (state_ff != ST_NORMAL) ||
                    (nxt_state != ST_NORMAL);
      lamp_ff[2] <= |(fault_ff | {1'b0, f_param, f_range, f_sensor});
      lamp_ff[1] <= f_press || !relower_ok_ff;
      lamp_ff[0] <= (state_ff != ST_NORMAL);
    end
  end

  assign valve_raise     = valve_ff[1];
  assign valve_lower     = valve_ff[0];
  assign lower_travel_80 = travel_ff;
  assign drive_inhibit   = inhibit_ff;
  assign lamp_error      = lamp_ff[2];
  assign lamp_warning    = lamp_ff[1];
  assign lamp_kneeling   = lamp_ff[0];
  assign kneel_state     = state_ff;
  assign fault_store     = fault_ff;
  assign sample_strobe   = sample_ff;
  assign cycle_tick      = cycle_ff;
endmodule // bkl_ctrl

// >>> src/bkl_map.vh
/*
 Constants for the bus kneeling level controller: cycle timing,
 sensor sampling, thresholds, state codes and reset values.
 Assumes a 200 MHz clk.
*/
`ifndef BKL_MAP_VH
`define BKL_MAP_VH

`define BKL_CLK_MHZ         200
`define BKL_CYCLE_MS        25
`define BKL_CYCLE_CNT       (`BKL_CYCLE_MS * 1000 * `BKL_CLK_MHZ)
`define BKL_SAMPLE_HZ       100
`define BKL_SAMPLE_CNT      ((`BKL_CLK_MHZ * 1000000) / `BKL_SAMPLE_HZ)
`define BKL_SPEED_LIMIT_KMH 5
`define BKL_TRAVEL_PCT      80

`define BKL_ST_NORMAL       2'h0
`define BKL_ST_LOWERING     2'h1
`define BKL_ST_LOWERED      2'h2
`define BKL_ST_LIFTING      2'h3

`define BKL_VALVE_RST       2'h0
`define BKL_FAULT_RST       4'h0

`endif

// >>> src/bkl_sync2.v
/*
 Two flip-flop synchroniser for a bus of asynchronous pin inputs.
 Assumes the bits are independent levels; no word coherence.
*/
`timescale 1ns/10ps
module bkl_sync2 #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         reset_n,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule // bkl_sync2

// >>> verif/bkl_ctrl_assertions.sv
/*
 Port-level checker for bkl_ctrl: cycle pacing, valves, sequencer
 and interlocks. Bound to every bkl_ctrl; counts follow CYCLE_CNT.
*/
`timescale 1ns/10ps
`include "bkl_map.vh"
module bkl_chk #(
  parameter [31:0] CYCLE_CNT = 20
) (
  // Clock and reset
  input wire       clk,
  input wire       reset_n,
  // Pins
  input wire       kneel_enable_sw,
  input wire       supply_press_ok,
  input wire       door_fully_open,
  // Outputs
  input wire       valve_raise,
  input wire       valve_lower,
  input wire       drive_inhibit,
  input wire [1:0] kneel_state,
  input wire       cycle_tick
);
  reg [31:0] gap_ff;
  reg        seen_ff;
  reg [2:0]  blk_ff;
  reg [2:0]  opn_ff;
  wire       blk = !kneel_enable_sw || !supply_press_ok;
  // Saturating counters give pins time to pass the synchroniser
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_ff <= 32'h0;
      seen_ff <= 1'b0;
      blk_ff <= 3'h0;
      opn_ff <= 3'h0;
    end else begin
      gap_ff <= cycle_tick ? 32'h1 : gap_ff + 32'h1;
      seen_ff <= seen_ff | cycle_tick;
      blk_ff <= !blk ? 3'h0 : blk_ff + {2'h0, ~&blk_ff};
      opn_ff <= !door_fully_open ? 3'h0 : opn_ff + {2'h0, ~&opn_ff};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  tick_period_a: assert property (seen_ff |-> gap_ff <= CYCLE_CNT &&
    cycle_tick == (gap_ff == CYCLE_CNT)) else $error("tick spacing");
  state_on_tick_a: assert property (!$stable(kneel_state) |->
    $past(cycle_tick)) else $error("state moved off tick");
  valve_on_tick_a: assert property (!$stable({valve_raise, valve_lower})
    |-> $past(cycle_tick)) else $error("valve moved off tick");
  valve_excl_a: assert property (!(valve_raise && valve_lower))
    else $error("both valves on");
  // Inhibit may trail the return to normal by one update
  inhibit_state_a: assert property (kneel_state != `BKL_ST_NORMAL
    |-> drive_inhibit) else $error("inhibit mismatch");
  no_enable_a: assert property (kneel_state == `BKL_ST_NORMAL &&
    blk_ff == 3'h7 |=> kneel_state != `BKL_ST_LOWERING)
    else $error("lowering while blocked");
  relower_a: assert property (kneel_state[1] |=>
    kneel_state != `BKL_ST_LOWERING) else $error("relower too early");
  door_lift_a: assert property (kneel_state != `BKL_ST_LIFTING &&
    opn_ff == 3'h7 |=> kneel_state != `BKL_ST_LIFTING)
    else $error("lift with door open");
  cover property (kneel_state == `BKL_ST_LOWERED);
  cover property (kneel_state == `BKL_ST_LIFTING && valve_raise);
  cover property (kneel_state == `BKL_ST_LOWERING && valve_lower);
endmodule // bkl_chk
bind bkl_ctrl bkl_chk #(.CYCLE_CNT(CYCLE_CNT)) chk_i (.*);

// >>> verif/bkl_far.sv
/*
 Far side model: body height follows the valves each cycle tick;
 door control holds full opening back, while drive inhibit is set, until 80 % travel is shown.
*/
`timescale 1ns/10ps
module bkl_far (
  // Clock and reset
  input wire        clk,
  input wire        reset_n,
  // From controller
  input wire        valve_raise,
  input wire        valve_lower,
  input wire        lower_travel_80,
  input wire        drive_inhibit,
  input wire        cycle_tick,
  // From bench
  input wire        open_req,
  // To controller
  output reg [15:0] height_raw,
  output reg        doors_closed,
  output reg        door_fully_open
);
  // One sensor fitted, start at the nominal driving height
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      height_raw <= 16'h0080;
      doors_closed <= 1'b1;
      door_fully_open <= 1'b0;
    end else begin
      if (cycle_tick && valve_lower && height_raw > 16'h0003)
        height_raw <= height_raw - 16'h0004;
      if (cycle_tick && valve_raise && height_raw < 16'h00fc)
        height_raw <= height_raw + 16'h0004;
      doors_closed <= !open_req;
      door_fully_open <= open_req && (lower_travel_80 || !drive_inhibit);
    end
  end
endmodule // bkl_far

// >>> verif/tb.sv
/*
 Self-checking bench for bkl_ctrl with the far side model.
 Assumes a 200 MHz clk and shortened cycle and sample counts.
*/
`timescale 1ns/10ps
`include "bkl_map.vh"
module tb;
  localparam CYC = 20;
  reg clk = 1'b0, reset_n = 1'b0, prm_we = 1'b0;
  reg [1:0] prm_sel = 2'h0;
  reg [15:0] prm_wdata = 16'h0;
  reg en = 1'b0, man = 1'b0, aut = 1'b0, emg = 1'b0, prs = 1'b0;
  reg opr = 1'b0, rev = 1'b0;
  reg [7:0] spd = 8'h00;
  reg [31:0] rs = 32'd64221;
  integer fails = 0, n_checks = 0, k;
  wire [15:0] hgt;
  wire [1:0] st;
  wire vr, vl, t80, inh, le, lw, lk, dc, dfo, tick;
  always #2.5 clk = ~clk;
  bkl_ctrl #(.CYCLE_CNT(CYC), .SAMPLE_CNT(7)) uut (.clk(clk),
    .reset_n(reset_n), .prm_we(prm_we), .prm_sel(prm_sel),
    .prm_wdata(prm_wdata), .sensor_wide(1'b0), .kneel_enable_sw(en),
    .manual_lower_btn(man), .auto_lower_req(aut), .emergency_sw(emg),
    .supply_press_ok(prs), .doors_closed(dc), .door_fully_open(dfo),
    .door_reversing(rev), .speed_kmh(spd), .height_raw(hgt),
    .sensor_fault_in(1'b0), .valve_raise(vr), .valve_lower(vl),
    .lower_travel_80(t80), .drive_inhibit(inh), .lamp_error(le),
    .lamp_warning(lw), .lamp_kneeling(lk), .kneel_state(st),
    .fault_store(), .sample_strobe(), .cycle_tick(tick));
  bkl_far far_i (.clk(clk), .reset_n(reset_n), .valve_raise(vr),
    .valve_lower(vl), .lower_travel_80(t80), .drive_inhibit(inh),
    .cycle_tick(tick), .open_req(opr), .height_raw(hgt),
    .doors_closed(dc), .door_fully_open(dfo));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task ticks(input integer n);
    repeat (n * CYC) @(negedge clk);
  endtask
  // Bounded wait so a stuck sequencer shows as a mismatch
  task wst(input [1:0] s);
    integer i;
    begin
      for (i = 0; i < 2000 && st !== s; i = i + 1)
        @(negedge clk);
      chk("state", s, st);
    end
  endtask
  task prm(input [1:0] s, input [15:0] d);
    begin
      prm_sel = s;
      prm_wdata = d;
      prm_we = 1'b1;
      @(negedge clk);
      prm_we = 1'b0;
      @(negedge clk);
    end
  endtask
  task conclude;
    begin
      if (fails == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #300000;
    fails = fails + 1;
    conclude;
  end
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk("reset", 16'h0, {vr, vl, t80, inh, le, lw, lk, st});
    prm(2'h0, 16'h0080);
    prm(2'h1, 16'h0040);
    prm(2'h2, 16'h0002);
    prm(2'h3, 16'h0000);
    for (k = 0; k < 5; k = k + 1) begin
      rs = xs(rs);
      en = (k != 0);
      prs = (k != 1);
      spd = (k == 2) ? 8'h05 : (k == 3) ? (8'h05 | rs[7:0]) : 8'h00;
      opr = (k == 4);
      man = (k < 4);
      aut = (k == 4);
      ticks(4);
      chk("refuse", `BKL_ST_NORMAL, st);
      man = 1'b0;
      aut = 1'b0;
      opr = 1'b0;
      ticks(2);
    end
    spd = 8'h04;
    man = 1'b1;
    wst(`BKL_ST_LOWERING);
    ticks(1);
    chk("inhibit", 16'h1, inh);
    chk("vlower", 16'h1, vl);
    wst(`BKL_ST_LOWERED);
    chk("trav80", 16'h1, t80);
    chk("lampk", 16'h1, lk);
    opr = 1'b1;
    ticks(1);
    man = 1'b0;
    ticks(3);
    chk("doorhold", `BKL_ST_LOWERED, st);
    opr = 1'b0;
    wst(`BKL_ST_LIFTING);
    ticks(1);
    chk("vraise", 16'h1, vr);
    rev = 1'b1;
    ticks(2);
    chk("pause", 16'h0, vr);
    rev = 1'b0;
    wst(`BKL_ST_NORMAL);
    ticks(1);
    // Low pressure seen earlier stays stored
    chk("lamps", 16'h4, {le, lw, inh});
    man = 1'b1;
    wst(`BKL_ST_LOWERING);
    ticks(2);
    man = 1'b0;
    ticks(3);
    chk("abort", `BKL_ST_LIFTING, st);
    man = 1'b1;
    ticks(1);
    chk("relower", `BKL_ST_LIFTING, st);
    man = 1'b0;
    wst(`BKL_ST_NORMAL);
    aut = 1'b1;
    wst(`BKL_ST_LOWERING);
    ticks(2);
    emg = 1'b1;
    ticks(3);
    chk("emerg", `BKL_ST_LIFTING, st);
    emg = 1'b0;
    aut = 1'b0;
    wst(`BKL_ST_NORMAL);
    aut = 1'b1;
    wst(`BKL_ST_LOWERED);
    chk("autot80", 16'h1, t80);
    aut = 1'b0;
    wst(`BKL_ST_LIFTING);
    wst(`BKL_ST_NORMAL);
    conclude;
  end
endmodule // tb
